// ---- core/gtc_prescaler.sv ----
/*
 Prescaler of the timer/counter: passes one tick in 1, 2, 4 or 8.
 Assumes tick_in is a one-cycle enable on clk; clr empties the count.
*/
`timescale 1ns/1ps

module gtc_prescaler
   import gtc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       clr,
   input  wire logic [1:0] sel,
   // ticks
   input  wire logic       tick_in,
   output logic            tick_out
);

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   wire  [2:0] mask = gtc_ps_mask(sel);

   assign tick_out = tick_in && ((cnt_q & mask) == mask);
   assign cnt_d    = clr ? 3'h0 : (tick_in ? 3'(cnt_q + 3'h1) : cnt_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ---- core/gtc_sync2.sv ----
/*
 Two flip-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps

module gtc_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // meta_q feeds q only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

// ---- core/gtc_timer.sv ----
/*
 Gated 16-bit timer/counter with prescaler, clock source selection,
 external clock synchronisation, gate control, overflow flag, sleep
 wake-up and capture/compare time base with special event clear.
 Assumes a single 25 MHz clk used as the oscillator clock; pins are
 asynchronous and pass two flip-flops; register port master is on clk.
*/
`timescale 1ns/1ps

// How it works
// - each byte read returns a stable registered counter byte, even counting externally.
// - gate comes from gate pin or comparator two output per source select.
// - gate enable ignored when off; when on, 1 gates counting, 0 counts freely.
// - gate polarity 1 counts while gate high, 0 while gate low.
// - wrapping from ffff to 0000 sets the overflow flag.
// - interrupt request needs flag plus overflow, peripheral and global enables.
// - overflow flag stays set until software clears it.
// - in sleep only unsynchronised external counting continues; all else freezes.
// - overflow in sleep with counter on and both enables raises wake.
// - capture mode copies the count into the capture/compare pair on event.
// - compare mode raises an event when count equals capture/compare pair.
// - special event trigger clears the counter and leaves the flag alone.
// - a counter byte write beats a coincident special event clear.
// - prescale field 00/01/10/11 divides by 1/2/4/8.
// - low-power oscillator enable acts only with internal oscillator, no clock out.
// - sync bit only matters for external clock: 1 bypasses, 0 synchronises.
// - source select 1 counts external rising edges; 0 uses internal clock.
// - on bit enables counting when set and halts it when clear.
// - a counter byte write loads the counter and empties the prescaler.
// - external counting needs a falling edge before the first counted rise.
module gtc_timer
   import gtc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // pins and comparator
   input  wire logic       external_clock_pin,
   input  wire logic       lp_osc_pin,
   input  wire logic       gate_pin,
   input  wire logic       comparator_two_output,
   // system
   input  wire logic       sleep,
   input  wire logic       internal_oscillator_no_clock_output_pin,
   input  wire logic       capture_event,
   // outputs
   output logic            irq_req,
   output logic            wake_req,
   output logic            compare_event,
   output logic            lp_osc_run
);

   // registers
   logic [7:0]            ctrl_q;
   logic [`GTC_AUX_HI:0]  aux_q;
   logic [`GTC_IRQ_HI:0]  irq_q;
   logic [15:0]           cnt_q;
   logic [15:0]           cnt_d;
   logic [15:0]           ccp_q;
   logic [15:0]           ccp_d;
   logic                  flag_d;
   logic [7:0]            rd_mux;
   logic                  ext_prev_q;
   logic                  armed_q;
   logic                  pend_q;
   logic [1:0]            qdiv_q;
   logic                  comp_held_q;
   logic                  eq_prev_q;
   logic [3:0]            pins_s;
   gtc_src_t              src;
   logic                  raw_tick;
   logic                  inc;

   // register decode
   wire wr_ctrl = reg_wr && (reg_addr == `GTC_ADDR_CTRL);
   wire wr_lo   = reg_wr && (reg_addr == `GTC_ADDR_CNT_LO);
   wire wr_hi   = reg_wr && (reg_addr == `GTC_ADDR_CNT_HI);
   wire wr_aux  = reg_wr && (reg_addr == `GTC_ADDR_AUX);
   wire wr_irq  = reg_wr && (reg_addr == `GTC_ADDR_IRQ);
   wire wr_cl   = reg_wr && (reg_addr == `GTC_ADDR_CCP_LO);
   wire wr_ch   = reg_wr && (reg_addr == `GTC_ADDR_CCP_HI);
   wire wr_cnt  = wr_lo || wr_hi;

   // control fields
   wire counter_on           = ctrl_q[`GTC_CTRL_ON];
   wire clock_source_select  = ctrl_q[`GTC_CTRL_CS];
   wire sync_bypass          = ctrl_q[`GTC_CTRL_SYNC];
   wire low_power_osc_enable = ctrl_q[`GTC_CTRL_LPEN];
   wire [1:0] prescale_select =
      ctrl_q[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO];
   wire gate_enable          = ctrl_q[`GTC_CTRL_GE];
   wire gate_polarity        = ctrl_q[`GTC_CTRL_GINV];
   wire gate_source_select   = aux_q[`GTC_AUX_GSS];
   wire alternate_clock_select = aux_q[`GTC_AUX_ACS];
   wire comp_sync_enable     = aux_q[`GTC_AUX_CSYNC];
   wire capture_mode         = aux_q[`GTC_AUX_CAP];
   wire compare_mode         = aux_q[`GTC_AUX_CMP];
   wire special_event_enable = aux_q[`GTC_AUX_SEV];
   wire overflow_flag        = irq_q[`GTC_IRQ_FLAG];
   wire overflow_irq_enable  = irq_q[`GTC_IRQ_IE];
   wire peripheral_irq_enable = irq_q[`GTC_IRQ_PERIPHERAL_IRQ_ENABLE];
   wire global_irq_enable    = irq_q[`GTC_IRQ_GIE];

   // pins are foreign to clk: two flops before any use
   gtc_sync2 #(
      .W (4)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({comparator_two_output, gate_pin, lp_osc_pin,
             external_clock_pin}),
      .q   (pins_s)
   );

   wire ext_clk_s = pins_s[0];
   wire lp_osc_s  = pins_s[1];
   wire gate_s    = pins_s[2];
   wire comp_s    = pins_s[3];

   // low-power oscillator only usable without clock output
   assign lp_osc_run = low_power_osc_enable && internal_oscillator_no_clock_output_pin;
   wire ext_level = lp_osc_run ? lp_osc_s : ext_clk_s;

   wire ext_rise = ext_level && !ext_prev_q;
   wire ext_fall = !ext_level && ext_prev_q;

   // sync bit is ignored on the internal clock
   wire async_mode = clock_source_select && sync_bypass;

   // internal instruction clock: one enable in four
   wire quarter_tick = (qdiv_q == `GTC_QDIV_LAST);

   assign src = clock_source_select ? GTC_SRC_EXT :
                (alternate_clock_select ? GTC_SRC_FULL : GTC_SRC_QUARTER);

   // a counted rise must follow a registered fall
   wire ext_count = ext_rise && armed_q;

   // synchronised external edges wait for the next internal phase tick
   wire pend_set = ext_count && !async_mode;

   always_comb begin
      case (src)
         GTC_SRC_QUARTER: raw_tick = quarter_tick;
         GTC_SRC_FULL:    raw_tick = 1'b1;
         GTC_SRC_EXT:     raw_tick = async_mode ? ext_count
                                     : (pend_q && quarter_tick);
         default:         raw_tick = 1'b0;
      endcase
   end

   // only unsynchronised external counting survives sleep
   wire frozen = sleep && !async_mode;

   // comparator level may be re-timed to the counter clock
   wire comp_level = comp_sync_enable ? comp_held_q : comp_s;
   wire gate_level = gate_source_select ? gate_s : comp_level;
   wire gate_ok    = !gate_enable || (gate_level == gate_polarity);
   wire run        = counter_on && !frozen && gate_ok;

   // a counter write also empties the prescaler
   gtc_prescaler u_ps (
      .clk      (clk),
      .rst      (rst),
      .clr      (wr_cnt),
      .sel      (prescale_select),
      .tick_in  (raw_tick && run),
      .tick_out (inc)
   );

   // special event clears on the first match cycle: ccp is the last count
   wire eq       = compare_mode && (cnt_q == ccp_q);
   wire sev      = eq && !eq_prev_q && special_event_enable;
   wire at_max   = (cnt_q == `GTC_CNT_MAX);
   wire overflow = inc && at_max && !wr_cnt && !sev;

   // counter next value: write beats special event beats increment
   always_comb begin
      if (wr_lo) begin
         cnt_d = {cnt_q[15:8], reg_wdata};
      end else if (wr_hi) begin
         cnt_d = {reg_wdata, cnt_q[7:0]};
      end else if (sev) begin
         cnt_d = `GTC_CNT_RST;
      end else if (inc) begin
         cnt_d = 16'(cnt_q + 16'h0001);
      end else begin
         cnt_d = cnt_q;
      end
   end

   // capture pair: capture event has priority over a software write
   always_comb begin
      ccp_d = ccp_q;
      if (capture_mode && capture_event) begin
         ccp_d = cnt_q;
      end else if (wr_cl) begin
         ccp_d = {ccp_q[15:8], reg_wdata};
      end else if (wr_ch) begin
         ccp_d = {reg_wdata, ccp_q[7:0]};
      end
   end

   // overflow set wins over a software clear in the same cycle
   assign flag_d = overflow ||
                   (wr_irq ? reg_wdata[`GTC_IRQ_FLAG] : overflow_flag);

   assign irq_req  = overflow_flag && overflow_irq_enable &&
                     peripheral_irq_enable && global_irq_enable;
   assign wake_req = counter_on && overflow_flag &&
                     overflow_irq_enable && peripheral_irq_enable;

   // read selection; bytes come straight from the counter flops
   always_comb begin
      case (reg_addr)
         `GTC_ADDR_CTRL:   rd_mux = ctrl_q;
         `GTC_ADDR_CNT_LO: rd_mux = cnt_q[7:0];
         `GTC_ADDR_CNT_HI: rd_mux = cnt_q[15:8];
         `GTC_ADDR_AUX:    rd_mux = {2'h0, aux_q};
         `GTC_ADDR_IRQ:    rd_mux = {4'h0, irq_q};
         `GTC_ADDR_CCP_LO: rd_mux = ccp_q[7:0];
         `GTC_ADDR_CCP_HI: rd_mux = ccp_q[15:8];
         default:          rd_mux = 8'h00;
      endcase
   end

   // register file
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q    <= `GTC_CTRL_RST;
         aux_q     <= `GTC_AUX_RST;
         irq_q     <= `GTC_IRQ_RST;
         reg_rdata <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
         end
         if (wr_aux) begin
            aux_q <= reg_wdata[`GTC_AUX_HI:0];
         end
         irq_q <= {(wr_irq ? reg_wdata[`GTC_IRQ_HI:1] : irq_q[`GTC_IRQ_HI:1]),
                   flag_d};
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // counting state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= `GTC_CNT_RST;
         ccp_q <= `GTC_CCP_RST;
      end else begin
         cnt_q <= cnt_d;
         ccp_q <= ccp_d;
      end
   end

   // edge tracking and clock phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_prev_q <= 1'b0;
         armed_q    <= 1'b0;
         pend_q     <= 1'b0;
         qdiv_q     <= 2'h0;
      end else begin
         ext_prev_q <= ext_level;
         qdiv_q     <= 2'(qdiv_q + 2'h1);
         // off or internal clock: the next external run must re-arm
         if (!counter_on || !clock_source_select) begin
            armed_q <= 1'b0;
         end else if (ext_fall) begin
            armed_q <= 1'b1;
         end
         pend_q <= (pend_q && !quarter_tick) || pend_set;
      end
   end

   // comparator re-timing and compare pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         comp_held_q   <= 1'b0;
         eq_prev_q     <= 1'b0;
         compare_event <= 1'b0;
      end else begin
         if (raw_tick) begin
            comp_held_q <= comp_s;
         end
         eq_prev_q     <= eq;
         compare_event <= eq && !eq_prev_q;
      end
   end

endmodule

// ---- shared/gtc_defs.svh ----
/*
 Register offsets, field positions, reset values and timing counts of the
 gated 16-bit timer/counter.
 Assumes a 4-bit register index and 8-bit register data.
*/
`ifndef GTC_DEFS_SVH
`define GTC_DEFS_SVH

// register indices on the plain register port
`define GTC_ADDR_CTRL      4'h0
`define GTC_ADDR_CNT_LO    4'h1
`define GTC_ADDR_CNT_HI    4'h2
`define GTC_ADDR_AUX       4'h3
`define GTC_ADDR_IRQ       4'h4
`define GTC_ADDR_CCP_LO    4'h5
`define GTC_ADDR_CCP_HI    4'h6

// timer_control fields
`define GTC_CTRL_ON        0
`define GTC_CTRL_CS        1
`define GTC_CTRL_SYNC      2
`define GTC_CTRL_LPEN      3
`define GTC_CTRL_PS_LO     4
`define GTC_CTRL_PS_HI     5
`define GTC_CTRL_GE        6
`define GTC_CTRL_GINV      7

// auxiliary control fields (gate source, clock alternate, capture unit)
`define GTC_AUX_GSS        0
`define GTC_AUX_ACS        1
`define GTC_AUX_CSYNC      2
`define GTC_AUX_CAP        3
`define GTC_AUX_CMP        4
`define GTC_AUX_SEV        5
`define GTC_AUX_HI         5

// flag and enable fields
`define GTC_IRQ_FLAG       0
`define GTC_IRQ_IE         1
`define GTC_IRQ_PERIPHERAL_IRQ_ENABLE       2
`define GTC_IRQ_GIE        3
`define GTC_IRQ_HI         3

// reset values
`define GTC_CTRL_RST       8'h00
`define GTC_AUX_RST        6'h01
`define GTC_IRQ_RST        4'h0
`define GTC_CNT_RST        16'h0000
`define GTC_CCP_RST        16'h0000

// counts
`define GTC_CNT_MAX        16'hffff
`define GTC_QDIV_LAST      2'h3
`define GTC_PS_MASK_1      3'h0
`define GTC_PS_MASK_2      3'h1
`define GTC_PS_MASK_4      3'h3
`define GTC_PS_MASK_8      3'h7

`endif

// ---- shared/gtc_pkg.sv ----
/*
 Types and helper functions of the gated 16-bit timer/counter.
 Assumes gtc_defs.svh is on the include path.
*/
`include "gtc_defs.svh"

package gtc_pkg;

   // counter clock source
   typedef enum logic [1:0] {
      GTC_SRC_QUARTER = 2'b00,
      GTC_SRC_FULL    = 2'b01,
      GTC_SRC_EXT     = 2'b10,
      GTC_SRC_NONE    = 2'b11
   } gtc_src_t;

   // prescale select to the mask of low counter bits that must be all ones
   function automatic logic [2:0] gtc_ps_mask(input logic [1:0] sel);
      case (sel)
         2'b00:   gtc_ps_mask = `GTC_PS_MASK_1;
         2'b01:   gtc_ps_mask = `GTC_PS_MASK_2;
         2'b10:   gtc_ps_mask = `GTC_PS_MASK_4;
         default: gtc_ps_mask = `GTC_PS_MASK_8;
      endcase
   endfunction

endpackage

// ---- verif/gtc_pins_model.sv ----
/*
 Far-side model: external count clock, gate pin and comparator output.
 Assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/1ps

module gtc_pins_model (
   // clock
   input wire logic clk,
   // pins
   output logic     external_clock_pin,
   output logic     gate_pin,
   output logic     comparator_two_output,
   output logic     lp_osc_pin
);
   initial begin
      external_clock_pin = 1'b0;
      gate_pin = 1'b0;
      comparator_two_output = 1'b0;
      lp_osc_pin = 1'b0;
   end

   // the clock stands low between bursts, slow enough for two-flop sync
   task automatic burst(input int n, input logic lp = 1'b0);
      repeat (n) begin
         repeat (5) @(posedge clk);
         external_clock_pin <= !lp;
         lp_osc_pin         <= lp;
         repeat (5) @(posedge clk);
         external_clock_pin <= 1'b0;
         lp_osc_pin         <= 1'b0;
      end
   endtask

   task automatic levels(input logic g, input logic c);
      gate_pin <= g;
      comparator_two_output <= c;
   endtask
endmodule

// ---- verif/gtc_timer_assertions.sv ----
/*
 Port assertions of the gated 16-bit timer/counter.
 Assumes the one-cycle register port and the register indices of gtc_defs.svh.
*/
`timescale 1ns/1ps
`include "gtc_defs.svh"

module gtc_timer_assertions (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // system and outputs
   input wire logic       internal_oscillator_no_clock_output_pin,
   input wire logic       irq_req,
   input wire logic       wake_req,
   input wire logic       compare_event,
   input wire logic       lp_osc_run
);
   // shadows built from the writes alone, so a stuck register shows up
   logic [7:0] ctrl_q;
   logic [7:0] aux_q;
   logic [7:0] irq_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 8'h00;
         aux_q  <= 8'h01;
         irq_q  <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `GTC_ADDR_CTRL) ctrl_q <= reg_wdata;
         if (reg_addr == `GTC_ADDR_AUX) aux_q <= reg_wdata;
         if (reg_addr == `GTC_ADDR_IRQ) irq_q <= reg_wdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   chk_ctrl_readback: assert property (
      $past(reg_rd) && $past(reg_addr) == `GTC_ADDR_CTRL
      |-> reg_rdata == $past(ctrl_q))
      else $error("control read back differs from last write");
   chk_irq_enables: assert property (irq_req |-> irq_q[3:1] == 3'h7)
      else $error("interrupt request without all three enables");
   chk_wake_enables: assert property (
      wake_req |-> ctrl_q[0] && irq_q[2:1] == 2'h3)
      else $error("wake request without on and both enables");
   chk_flag_holds: assert property (irq_req && !reg_wr |=> irq_req)
      else $error("interrupt request dropped without a write");
   chk_lp_osc: assert property (
      lp_osc_run == (ctrl_q[3] && internal_oscillator_no_clock_output_pin))
      else $error("low power oscillator run level wrong");
   chk_cmp_mode: assert property (compare_event |-> aux_q[4])
      else $error("compare event outside compare mode");
   chk_cmp_pulse: assert property (compare_event |=> !compare_event)
      else $error("compare event longer than one cycle");
endmodule

bind gtc_timer gtc_timer_assertions i_chk (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .internal_oscillator_no_clock_output_pin(internal_oscillator_no_clock_output_pin), .irq_req(irq_req),
   .wake_req(wake_req), .compare_event(compare_event),
   .lp_osc_run(lp_osc_run));

// ---- verif/testbench.sv ----
/*
 Self-checking bench of the gated 16-bit timer/counter.
 Assumes gtc_defs.svh on the include path and the pin model beside it.
*/
`timescale 1ns/1ps
`include "gtc_defs.svh"

module testbench;
   logic       clk, rst, reg_wr, reg_rd, sleep, internal_oscillator_no_clock_output_pin;
   logic       capture_event, irq_req, wake_req, compare_event, lp_osc_run;
   logic       ext_pin, lp_pin, gate_pin, cmp_out;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   int         errors = 0;
   int         n_checks = 0;

   gtc_timer i_gtc_timer (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_clock_pin(ext_pin), .lp_osc_pin(lp_pin),
      .gate_pin(gate_pin), .comparator_two_output(cmp_out),
      .sleep(sleep), .internal_oscillator_no_clock_output_pin(internal_oscillator_no_clock_output_pin),
      .capture_event(capture_event), .irq_req(irq_req),
      .wake_req(wake_req), .compare_event(compare_event),
      .lp_osc_run(lp_osc_run));

   gtc_pins_model i_gtc_pins_model (
      .clk(clk), .external_clock_pin(ext_pin), .gate_pin(gate_pin),
      .comparator_two_output(cmp_out), .lp_osc_pin(lp_pin));

   task automatic test_done;
      if (errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk);
   endtask

   // difference of two low-byte reads 64 cycles apart
   task automatic meas(output logic [7:0] d);
      logic [7:0] a, b;
      rd(`GTC_ADDR_CNT_LO, a);
      cyc(61);
      rd(`GTC_ADDR_CNT_LO, b);
      d = b - a;
   endtask

   // halted counter, cleared bytes and flag before anything runs
   task automatic clear;
      wr(`GTC_ADDR_CTRL, 8'h00);
      wr(`GTC_ADDR_CNT_LO, 8'h00);
      wr(`GTC_ADDR_CNT_HI, 8'h00);
      wr(`GTC_ADDR_IRQ, 8'h00);
   endtask

   task automatic t_reset;
      logic [7:0] d;
      rd(`GTC_ADDR_CTRL, d);
      check("control reset", d, 8'h00);
      rd(`GTC_ADDR_AUX, d);
      check("aux reset", d, 8'h01);
      rd(`GTC_ADDR_IRQ, d);
      check("irq reset", d, 8'h00);
      rd(4'hf, d);
      check("unmapped read", d, 8'h00);
   endtask

   task automatic t_prescale;
      logic [7:0] d;
      wr(`GTC_ADDR_AUX, 8'h03);
      for (int p = 0; p < 4; p++) begin
         wr(`GTC_ADDR_CTRL, {2'b00, p[1:0], 4'h1});
         cyc(8);
         meas(d);
         check("prescaled rate", d, 8'd64 >> p);
      end
      wr(`GTC_ADDR_AUX, 8'h01);
      wr(`GTC_ADDR_CTRL, 8'h01);
      meas(d);
      check("quarter rate", d, 8'd16);
   endtask

   task automatic t_gate;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         // comparator output re-timed whenever it gates
         wr(`GTC_ADDR_AUX, i[0] ? 8'h03 : 8'h06);
         i_gtc_pins_model.levels(i[2] ^ !i[0], i[2] ^ i[0]);
         wr(`GTC_ADDR_CTRL, {i[1], 7'h41});
         cyc(8);
         meas(d);
         check("gated rate", d, (i[2] == i[1]) ? 8'd64 : 8'd0);
      end
      wr(`GTC_ADDR_CTRL, 8'h01);
      meas(d);
      check("gate ignored", d, 8'd64);
      wr(`GTC_ADDR_CTRL, 8'hc0);
      meas(d);
      check("halted", d, 8'd0);
   endtask

   task automatic t_overflow;
      logic [7:0] d;
      int         n;
      clear();
      wr(`GTC_ADDR_AUX, 8'h03);
      wr(`GTC_ADDR_CNT_LO, 8'hfe);
      wr(`GTC_ADDR_CNT_HI, 8'hff);
      wr(`GTC_ADDR_IRQ, 8'h0e);
      check("irq before wrap", irq_req, 1'b0);
      wr(`GTC_ADDR_CTRL, 8'h01);
      for (n = 0; n < 40 && irq_req !== 1'b1; n++) @(posedge clk);
      check("overflow wait", n < 40, 1'b1);
      if (n == 40) begin
         test_done();
      end
      #1;
      check("wake on wrap", wake_req, 1'b1);
      wr(`GTC_ADDR_CTRL, 8'h00);
      rd(`GTC_ADDR_CNT_HI, d);
      check("carry into high", d, 8'h00);
      check("flag sticky", irq_req, 1'b1);
      wr(`GTC_ADDR_IRQ, 8'h0b);
      check("irq peripheral off", irq_req, 1'b0);
      wr(`GTC_ADDR_IRQ, 8'h0f);
      cyc(5);
      check("flag stays", irq_req, 1'b1);
      wr(`GTC_ADDR_IRQ, 8'h0e);
      check("flag cleared", irq_req, 1'b0);
   endtask

   task automatic t_special;
      logic [7:0] d;
      int         n;
      clear();
      wr(`GTC_ADDR_CCP_LO, 8'h10);
      wr(`GTC_ADDR_CCP_HI, 8'h00);
      // synchronous fosc counting, so no trigger is missed
      wr(`GTC_ADDR_AUX, 8'h33);
      wr(`GTC_ADDR_CTRL, 8'h01);
      for (n = 0; n < 40 && compare_event !== 1'b1; n++) @(posedge clk);
      check("compare event", n < 40, 1'b1);
      cyc(200);
      wr(`GTC_ADDR_CTRL, 8'h00);
      rd(`GTC_ADDR_CNT_LO, d);
      check("period bound", d <= 8'h10, 1'b1);
      rd(`GTC_ADDR_IRQ, d);
      check("no flag on clear", d[0], 1'b0);
   endtask

   task automatic t_capture;
      logic [7:0] lo, hi;
      wr(`GTC_ADDR_AUX, 8'h0b);
      wr(`GTC_ADDR_CNT_LO, 8'h34);
      wr(`GTC_ADDR_CNT_HI, 8'h12);
      @(posedge clk);
      capture_event <= 1'b1;
      @(posedge clk);
      capture_event <= 1'b0;
      rd(`GTC_ADDR_CCP_LO, lo);
      rd(`GTC_ADDR_CCP_HI, hi);
      check("captured count", {hi, lo}, 16'h1234);
   endtask

   task automatic t_ext;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         clear();
         wr(`GTC_ADDR_AUX, 8'h01);
         wr(`GTC_ADDR_CTRL, i[0] ? 8'h07 : 8'h03);
         sleep <= i[1];
         i_gtc_pins_model.burst(6);
         cyc(8);
         sleep <= 1'b0;
         rd(`GTC_ADDR_CNT_LO, d);
         // first rise is not counted: no fall seen yet
         check("external count", d, (i[1] && !i[0]) ? 8'd0 : 8'd5);
      end
      wr(`GTC_ADDR_AUX, 8'h03);
      wr(`GTC_ADDR_CTRL, 8'h01);
      sleep <= 1'b1;
      meas(d);
      check("internal in sleep", d, 8'd0);
      sleep <= 1'b0;
   endtask

   task automatic t_lp;
      logic [7:0] d;
      wr(`GTC_ADDR_CTRL, 8'h08);
      check("lp osc no internal_oscillator", lp_osc_run, 1'b0);
      internal_oscillator_no_clock_output_pin <= 1'b1;
      @(posedge clk);
      #1;
      check("lp osc run", lp_osc_run, 1'b1);
      clear();
      wr(`GTC_ADDR_CTRL, 8'h0f);
      i_gtc_pins_model.burst(6, 1'b1);
      cyc(8);
      rd(`GTC_ADDR_CNT_LO, d);
      check("lp osc count", d, 8'd5);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sleep = 1'b0;
      internal_oscillator_no_clock_output_pin = 1'b0;
      capture_event = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_prescale();
      t_gate();
      t_overflow();
      t_special();
      t_capture();
      t_ext();
      t_lp();
      test_done();
   end
endmodule
